/* File: hw/gray_pwm_regs.svh */
`ifndef GRAY_PWM_REGS_SVH
`define GRAY_PWM_REGS_SVH

// Register byte addresses
`define ADDR_CONFIG   8'h00
`define ADDR_LATCH    8'h04
`define ADDR_STATUS   8'h08
`define ADDR_GRAY0    8'h40
`define ADDR_GRAY15   8'h7c

// Configuration field positions
`define CFG_TO_DIS    0
`define CFG_SYNC      10
`define CFG_MODE_LO   11
`define CFG_MODE_HI   12
`define CFG_DEPTH     13
`define CFG_RESET     32'h0000_0000

// Counting modes
`define MODE_X64      2'h0
`define MODE_X16      2'h1
`define MODE_X4       2'h2
`define MODE_DIRECT   2'h3

// Segment lengths, last step index
`define MSB10_TOP     16'h03fe
`define MSB6_TOP      16'h003e
`define LSB_TOP       16'h003f
`define DIR16_TOP     16'hffff
`define DIR12_TOP     16'h0fff

// Prescale tops (gray clocks per MSB step minus one)
`define PRE_X16_TOP   4'h3
`define PRE_X4_TOP    4'hf

// Repeat tops (MSB segments per cycle minus one)
`define SEG_X64_TOP   6'h3f
`define SEG_X16_TOP   6'h0f
`define SEG_X4_TOP    6'h03

// Gray clock loss timeout
`define TIMEOUT_MS    1000
`define CLK_MHZ       250
`define TIMEOUT_CYC   (`TIMEOUT_MS * `CLK_MHZ * 1000)

`endif

/* File: hw/gray_pwm_pkg.sv */
package gray_pwm_pkg;

  typedef logic [15:0] gray_word_type;

  typedef enum logic {
    PHASE_MSB,
    PHASE_LSB
  } phase_type;

endpackage : gray_pwm_pkg

/* File: hw/scrambled_gray_pwm_counter.sv */
`timescale 1ns/100ps
`include "gray_pwm_regs.svh"

module scrambled_gray_pwm_counter #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        gray_clock_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic      [15:0] chan_on_o
);

  logic                          gray_clock_q;
  logic [31:0]                   cfg;
  logic                          blanked;
  logic                          gray_clock_seen;
  logic [27:0]                   idle_cnt;
  logic [3:0]                    pre;
  logic [15:0]                   step;
  logic [5:0]                    seg;
  gray_pwm_pkg::phase_type       phase;
  logic                          data_new;
  gray_pwm_pkg::gray_word_type   pend   [16];
  gray_pwm_pkg::gray_word_type   active [16];
  gray_pwm_pkg::gray_word_type   cmp    [16];

  // Decoding
  wire        gedge     = gray_clock_i & ~gray_clock_q;
  wire        wr_cfg    = wr_i & (addr_i == `ADDR_CONFIG);
  wire        wr_latch  = wr_i & (addr_i == `ADDR_LATCH);
  wire        gray_hit  = (addr_i >= `ADDR_GRAY0) &&
                          (addr_i <= `ADDR_GRAY15) &&
                          (addr_i[1:0] == 2'h0);
  wire [3:0]  gray_idx  = addr_i[5:2];

  wire [1:0]  mode      = cfg[`CFG_MODE_HI:`CFG_MODE_LO];
  wire        depth12   = cfg[`CFG_DEPTH];
  wire        manual    = cfg[`CFG_SYNC];
  wire        to_en     = ~cfg[`CFG_TO_DIS];
  wire        direct    = (mode == `MODE_DIRECT);
  wire        in_lsb    = (phase == gray_pwm_pkg::PHASE_LSB);

  // Prescaler top per mode
  wire [3:0]  pre_top   = (mode == `MODE_X16) ? `PRE_X16_TOP :
                          (mode == `MODE_X4)  ? `PRE_X4_TOP  :
                          4'h0;

  // MSB repeat count per mode
  wire [5:0]  seg_top   = (mode == `MODE_X64) ? `SEG_X64_TOP :
                          (mode == `MODE_X16) ? `SEG_X16_TOP :
                          (mode == `MODE_X4)  ? `SEG_X4_TOP  :
                          6'h00;

  // Last step index of the running segment
  wire [15:0] step_top  = direct ? (depth12 ? `DIR12_TOP : `DIR16_TOP) :
                          in_lsb ? `LSB_TOP :
                          (depth12 ? `MSB6_TOP : `MSB10_TOP);

  wire        run       = gedge & ~blanked;
  // The LSB segment and direct mode count every gray clock
  wire        pre_wrap  = in_lsb | direct | (pre >= pre_top);
  wire        step_adv  = run & pre_wrap;
  // >= keeps a mid-cycle mode change from running away
  wire        seg_end   = step_adv & (step >= step_top);
  wire        last_msb  = ~in_lsb & ~direct & (seg >= seg_top);
  wire        cyc_end   = seg_end & (in_lsb | direct);

  // Leaving timeout needs both a gray clock and a fresh latch
  wire        restart   = blanked & wr_latch & (gray_clock_seen | gedge);
  wire        timed_out = to_en & ~blanked &
                          (idle_cnt >= 28'(TIMEOUT_CYCLES - 1));

  // Data moves to the active buffer
  wire        xfer      = restart |
                          (manual  & wr_latch) |
                          (~manual & data_new & cyc_end);
  wire        seg_load  = seg_end | xfer;

  // Phase of the segment that starts after this edge
  wire        next_lsb  = restart      ? 1'b0 :
                          ~seg_end     ? in_lsb :
                          last_msb;

  wire [15:0] next_step = (restart | seg_end) ? 16'h0000 :
                          step_adv ? step + 16'h0001 : step;

  wire [3:0]  next_pre  = (restart | step_adv) ? 4'h0 :
                          (run & ~in_lsb) ? pre + 4'h1 : pre;

  wire [5:0]  next_seg  = restart ? 6'h00 :
                          ~seg_end ? seg :
                          (in_lsb | direct | last_msb) ? (last_msb ? seg : 6'h00) :
                          seg + 6'h01;

  wire [15:0] next_step_q = next_step;

  // Register read data
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_i == `ADDR_CONFIG) begin
      next_rdata = cfg;
    end else if (addr_i == `ADDR_STATUS) begin
      next_rdata = {18'h0, seg, 6'h0, in_lsb, blanked};
    end else if (gray_hit) begin
      next_rdata = {16'h0, pend[gray_idx]};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // Configuration; only documented fields are writable
  localparam logic [31:0] CFG_MASK = (32'h1 << `CFG_TO_DIS) |
                                     (32'h1 << `CFG_SYNC) |
                                     (32'h1 << `CFG_MODE_LO) |
                                     (32'h1 << `CFG_MODE_HI) |
                                     (32'h1 << `CFG_DEPTH);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= `CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= wdata_i & CFG_MASK;
    end
  end

  // Gray clock edge and loss watchdog
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Seen as high so a gray clock parked high is not taken as an edge
      gray_clock_q   <= 1'b1;
      idle_cnt <= 28'h000_0000;
    end else begin
      gray_clock_q <= gray_clock_i;
      if (gedge) begin
        idle_cnt <= 28'h000_0000;
      end else if (idle_cnt != 28'hfff_ffff) begin
        idle_cnt <= idle_cnt + 28'h000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blanked   <= 1'b0;
      gray_clock_seen <= 1'b0;
    end else if (restart) begin
      blanked   <= 1'b0;
      gray_clock_seen <= 1'b0;
    end else if (timed_out) begin
      blanked   <= 1'b1;
      gray_clock_seen <= 1'b0;
    end else if (blanked & gedge) begin
      gray_clock_seen <= 1'b1;
    end
  end

  // Pending flag: a latch in the transfer cycle is kept
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_new <= 1'b0;
    end else begin
      data_new <= (wr_latch & ~manual & ~restart) | (data_new & ~xfer);
    end
  end

  // Segment counters
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre   <= 4'h0;
      step  <= 16'h0000;
      seg   <= 6'h00;
      phase <= gray_pwm_pkg::PHASE_MSB;
    end else begin
      pre   <= next_pre;
      step  <= next_step_q;
      seg   <= next_seg;
      phase <= next_lsb ? gray_pwm_pkg::PHASE_LSB : gray_pwm_pkg::PHASE_MSB;
    end
  end

  // Per-channel buffers, compare slice and output
  for (genvar ch = 0; ch < 16; ch++) begin : g_chan
    wire                         wr_gray = wr_i & gray_hit & (gray_idx == 4'(ch));
    wire [15:0]                  src     = xfer ? pend[ch] : active[ch];
    logic [15:0]                 slice;

    always_comb begin
      if (direct) begin
        slice = depth12 ? {4'h0, src[15:4]} : src;
      end else if (next_lsb) begin
        slice = depth12 ? {10'h0, src[9:4]} : {10'h0, src[5:0]};
      end else begin
        slice = depth12 ? {10'h0, src[15:10]} : {6'h0, src[15:6]};
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pend[ch] <= 16'h0000;
      end else if (wr_gray) begin
        pend[ch] <= wdata_i[15:0];
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        active[ch] <= 16'h0000;
      end else if (xfer) begin
        active[ch] <= pend[ch];
      end
    end

    // Compare value holds through a segment unless a manual latch transfer reloads it mid-segment
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cmp[ch] <= 16'h0000;
      end else if (seg_load) begin
        cmp[ch] <= slice;
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        chan_on_o[ch] <= 1'b0;
      end else begin
        chan_on_o[ch] <= ~blanked & ~timed_out & (step < cmp[ch]);
      end
    end
  end

endmodule : scrambled_gray_pwm_counter

/* File: tb/gray_host.sv */
`timescale 1ns/100ps
module gray_host (
  input  wire logic       clk_sys_i,
  input  wire logic       run_i,
  input  wire logic [1:0] half_i,
  output logic            gray_o
);
  logic [1:0] cnt = 2'h0;
  initial gray_o = 1'b0;
  // Free running, blind to data updates; a stall simply holds the level
  always @(posedge clk_sys_i) begin
    cnt <= cnt >= half_i ? 2'h1 : cnt + 2'h1;
    if (cnt >= half_i)
      gray_o <= gray_o ^ run_i;
  end
endmodule : gray_host

/* File: tb/pwm_properties.sv */
`timescale 1ns/100ps
`include "gray_pwm_regs.svh"
module pwm_props #(
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        gray_clock_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [15:0] chan_on_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] cfg;
  logic [31:0] idle;
  logic        gq;
  wire         grise = gray_clock_i & ~gq;
  wire         sta_rd = rd_i && addr_i == `ADDR_STATUS;
  // Slack of a few cycles so the blanking pipeline is not judged too early
  wire         lost = idle > TIMEOUT_CYCLES + 4 && !cfg[0];
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg  <= 32'h0;
      idle <= 32'h0;
      gq   <= 1'b1;
    end else begin
      gq   <= gray_clock_i;
      idle <= grise ? 32'h0 : idle + 32'h1;
      if (wr_i && addr_i == `ADDR_CONFIG)
        cfg <= wdata_i & 32'h3c01;
    end
  end
  property p_cfg_read; rd_i && addr_i == `ADDR_CONFIG |=> rdata_o == $past(cfg); endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
  property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_blank; lost |-> chan_on_o == 16'h0; endproperty
  a_blank: assert property (p_blank) else $error("outputs lit after gray loss");
  property p_blank_flag; sta_rd && lost |=> rdata_o[0]; endproperty
  a_blank_flag: assert property (p_blank_flag) else $error("blank flag missing");
  property p_no_blank; sta_rd && cfg[0] |=> !rdata_o[0]; endproperty
  a_no_blank: assert property (p_no_blank) else $error("blanked while disabled");
  property p_seg_x16; sta_rd && cfg[12:11] == 2'h1 |=> rdata_o[13:8] < 6'h10; endproperty
  a_seg_x16: assert property (p_seg_x16) else $error("segment index past 15");
  property p_seg_x4; sta_rd && cfg[12:11] == 2'h2 |=> rdata_o[13:8] < 6'h04; endproperty
  a_seg_x4: assert property (p_seg_x4) else $error("segment index past 3");
  property p_auto_hold;
    $changed(chan_on_o) && $past(chan_on_o) != 16'h0 && !cfg[10] |-> $past(grise, 2);
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("output moved off a step");
  c_lost: cover property (lost);
  c_manual: cover property (cfg[10] && wr_i && addr_i == `ADDR_LATCH);
  c_x4: cover property (sta_rd && cfg[12:11] == 2'h2);
endmodule : pwm_props

/* File: tb/scrambled_gray_pwm_counter_tb_top.sv */
`timescale 1ns/100ps
`include "gray_pwm_regs.svh"
module scrambled_gray_pwm_counter_tb_top;
  localparam int TO = 200;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
  logic        gray, gq = 1'b0, c0q = 1'b0, meas = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [1:0]  half = 2'h1;
  logic [15:0] chan;
  logic [15:0] val [16];
  int          ontime [16] = '{default: 0};
  int          diff [16];
  int          segs [5] = '{63, 252, 1008, 4096, 1023};
  int          reps [4] = '{64, 16, 4, 0};
  int          fails = 0, comparisons = 0, gcnt = 0, last = 0, rises = 0, seg, k;
  always #2 clk = ~clk;
  gray_host host (.clk_sys_i(clk), .run_i(run), .half_i(half), .gray_o(gray));
  scrambled_gray_pwm_counter #(.TIMEOUT_CYCLES(TO)) dut (.clk_sys_i(clk), .rst_n_i(rst_n),
    .gray_clock_i(gray), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .chan_on_o(chan));
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] exp_on(logic [15:0] v);
    return {20'h0, v[15:4]};
  endfunction : exp_on
  task wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task rd_reg(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  task wait_gray(int n);
    int g;
    g = gcnt + n;
    while (gcnt < g) @(negedge clk);
  endtask : wait_gray
  // On-time is summed per gray clock, so any window of one full cycle gives the total
  task window(int n);
    int s [16];
    s = ontime;
    rises = 0;
    meas = 1'b1;
    wait_gray(n);
    meas = 1'b0;
    foreach (s[c])
      diff[c] = ontime[c] - s[c];
  endtask : window
  task summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    gq  <= gray;
    c0q <= chan[0];
    if (gray && !gq) begin
      gcnt <= gcnt + 1;
      foreach (ontime[c])
        ontime[c] <= ontime[c] + int'(chan[c]);
    end
    if (chan[0] && !c0q) begin
      if (meas && rises != 0)
        check("ch0 gap", 32'(gcnt - last inside {seg, 64}), 32'h1);
      last  <= gcnt;
      rises <= rises + 1;
    end
  end
  initial begin
    // Worst case of all passes is about 75000 cycles
    repeat (95000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(32'h25bc));
    for (int m = 0; m < 5; m++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      run   <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(`ADDR_CONFIG, r);
      check("config reset", r, 32'h0);
      wr_reg(`ADDR_CONFIG, {18'h0, m < 4, m[1:0], m != 3, 10'h0});
      rd_reg(8'h20, r);
      check("unmapped", r, 32'h0);
      seg = segs[m];
      foreach (val[c]) begin
        val[c] = c == 0 ? (m < 4 ? 16'h0410 : 16'h0041) :
                 c == 1 ? 16'hffff : c == 2 ? 16'h0 : 16'($urandom);
        wr_reg(`ADDR_GRAY0 + 8'(4 * c), {16'h0, val[c]});
      end
      rd_reg(`ADDR_GRAY0 + 8'h3c, r);
      check("gray word", r, {16'h0, val[15]});
      half <= m == 3 ? 2'h1 : 2'($urandom_range(2, 1));
      run  <= 1'b1;
      k = m == 3 ? 200 + $urandom_range(1500) : 2;
      wait_gray(k);
      // Issued just after a gray edge so a manual load lands on a known step
      wr_reg(`ADDR_LATCH, 32'h0);
      wait_gray(2);
      if (m == 3) begin
        window(3900 - k);
        foreach (diff[c])
          check("held", 32'(diff[c]), 32'h0);
        wait_gray(300);
      end
      window(m < 4 ? 4096 : 2100);
      if (m < 4) begin
        foreach (diff[c])
          check("on time", 32'(diff[c]), exp_on(val[c]));
        check("ch0 rises", 32'(rises), 32'(reps[m] + 1));
      end
      rd_reg(`ADDR_STATUS, r);
      check("blank flag", {31'h0, r[0]}, 32'h0);
    end
    run <= 1'b0;
    repeat (TO + 20) @(posedge clk);
    rd_reg(`ADDR_STATUS, r);
    check("blanked", {15'h0, r[0], chan}, 32'h10000);
    run <= 1'b1;
    wait_gray(2);
    wr_reg(`ADDR_LATCH, 32'h0);
    wait_gray(4);
    rd_reg(`ADDR_STATUS, r);
    check("resumed", {15'h0, chan[1], 15'h0, r[0]}, 32'h10000);
    wr_reg(`ADDR_CONFIG, 32'h1);
    run <= 1'b0;
    repeat (TO + 50) @(posedge clk);
    rd_reg(`ADDR_STATUS, r);
    check("kept lit", {15'h0, chan[1], 15'h0, r[0]}, 32'h10000);
    summarize();
  end
endmodule : scrambled_gray_pwm_counter_tb_top
bind scrambled_gray_pwm_counter pwm_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .gray_clock_i(gray_clock_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_on_o(chan_on_o));
